// *** src/cfrffp_pkg.sv ***
package cfrffp_pkg;

    // ------------------------------------------------------------
    // Frame field widths
    // ------------------------------------------------------------
    localparam int ID_W      = 29;
    localparam int DLC_W     = 4;
    localparam int LABEL_W   = 16;
    localparam int PAY_BYTES = 64;
    localparam int PAY_W     = PAY_BYTES * 8;
    localparam int CODE_W    = 3;
    localparam int COUNT_W   = 8;
    // Transmit entry is {id, ide, rtr, fdf, brs, dlc, payload}.
    localparam int TX_W      = ID_W + 4 + DLC_W + PAY_W;
    // Receive entry appends the label between dlc and payload.
    localparam int RX_W      = TX_W + LABEL_W;

    // ------------------------------------------------------------
    // Clock and bit rates
    // ------------------------------------------------------------
    localparam int CLK_HZ   = 20_000_000;
    localparam int NOM_BPS  = 1_000_000;
    localparam int DATA_BPS = 2_000_000;
    localparam int NOM_CYC  = CLK_HZ / NOM_BPS;
    localparam int DATA_CYC = CLK_HZ / DATA_BPS;

    // ------------------------------------------------------------
    // Depths and configuration codes
    // ------------------------------------------------------------
    localparam int RX_DEPTH_DEF  = 8;
    localparam int TX_DEPTH_DEF  = 4;
    localparam int OUT_BUF_DEPTH = 2;
    localparam int THR_DEN       = 8;
    localparam int MAX_RULES     = 2;
    localparam logic [CODE_W-1:0] DEPTH_CODE_4 = 3'h1;
    localparam logic [CODE_W-1:0] DEPTH_CODE_8 = 3'h2;

    // ------------------------------------------------------------
    // Acceptance rule table, entry 0 in the low slot
    // ------------------------------------------------------------
    localparam logic [MAX_RULES-1:0][ID_W-1:0]    RULE_ID      = {29'h0000002, 29'h0000001};
    localparam logic [MAX_RULES-1:0][ID_W-1:0]    RULE_ID_MASK = {29'h1FFFFFFF, 29'h1FFFFFFF};
    localparam logic [MAX_RULES-1:0]              RULE_IDE      = 2'h3;
    localparam logic [MAX_RULES-1:0]              RULE_IDE_MASK = 2'h3;
    localparam logic [MAX_RULES-1:0]              RULE_RTR      = 2'h0;
    localparam logic [MAX_RULES-1:0]              RULE_RTR_MASK = 2'h3;
    localparam logic [MAX_RULES-1:0]              RULE_LB       = 2'h0;
    localparam logic [MAX_RULES-1:0][LABEL_W-1:0] RULE_LABEL   = {16'h0124, 16'h0123};
    localparam logic [MAX_RULES-1:0]              RULE_RX_ROUTE   = 2'h3;
    localparam logic [MAX_RULES-1:0]              RULE_TXRX_ROUTE = 2'h0;
    localparam logic [MAX_RULES-1:0]              RULE_BUF_VALID  = 2'h0;

    // ------------------------------------------------------------
    // Code decoders
    // ------------------------------------------------------------
    // Depth code: 1 gives four messages, 2 and above eight, capped at the built size.
    function automatic int depth_of(input logic [CODE_W-1:0] code, input int built);
        int d;
        d = (code <= DEPTH_CODE_4) ? 4 : 8;
        return (d > built) ? built : d;
    endfunction : depth_of

    // Payload size code to bytes kept per message; code 7 keeps all 64.
    function automatic int size_bytes(input logic [CODE_W-1:0] code);
        case (code)
            3'h0:    return 8;
            3'h1:    return 12;
            3'h2:    return 16;
            3'h3:    return 20;
            3'h4:    return 24;
            3'h5:    return 32;
            3'h6:    return 48;
            default: return 64;
        endcase
    endfunction : size_bytes

endpackage : cfrffp_pkg

// *** src/cfrffp_fifo.sv ***
`timescale 1ns/10ps

module cfrffp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 2,
    localparam int CW   = $clog2(DEPTH + 1),
    localparam int AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          rst_b,
    // Configured capacity, at most DEPTH
    input  wire logic [CW-1:0] limit,
    // Fill side
    input  wire logic          in_valid,
    output      logic          in_ready,
    input  wire logic [W-1:0]  in_data,
    // Drain side
    output      logic          out_valid,
    input  wire logic          out_ready,
    output      logic [W-1:0]  out_data,
    // Occupancy
    output      logic [CW-1:0] count
);

    if (DEPTH < 2) begin : g_bad_depth
        $error("cfrffp_fifo needs at least two entries");
    end

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] rd_ptr_r;
    logic [AW-1:0] wr_ptr_r;
    logic [CW-1:0] count_r;
    wire           push = in_valid && in_ready;
    wire           pop  = out_valid && out_ready;

    // ------------------------------------------------------------
    // Handshake decode
    // ------------------------------------------------------------
    // Ready follows the configured limit so a smaller depth code really stalls the source.
    assign in_ready  = count_r < limit;
    assign out_valid = count_r != '0;
    assign out_data  = mem_r[rd_ptr_r];
    assign count     = count_r;

    // Pointers and count; a push and a pop together leave the count alone.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_ptr_r <= '0;
            wr_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            if (pop)  rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            if (push && !pop) count_r <= count_r + 1'b1;
            else if (pop && !push) count_r <= count_r - 1'b1;
        end
    end

    // Storage carries data only, so it needs no reset.
    always_ff @(posedge clock) begin
        if (push) mem_r[wr_ptr_r] <= in_data;
    end

    chk_fifo_count_up: assert property (@(posedge clock) disable iff (!rst_b) // see RL3
        push && !pop |=> count_r == $past(count_r) + 1'b1)
        else $error("fifo count did not rise on push");
    chk_fifo_bound: assert property (@(posedge clock) disable iff (!rst_b) // see RL3
        $stable(limit) && count_r == limit |=> count_r <= limit)
        else $error("fifo filled beyond its limit");

endmodule : cfrffp_fifo

// *** src/cfrffp_top.sv ***
`timescale 1ns/10ps
// Functional notes
// RL1: Transmit FIFO sends 64-byte FD frames back to back.
// RL2: Host loads and requests one frame at a time.
// RL3: Receive FIFO holds eight messages at depth code 2.
// RL4: Interrupt when fill reaches two eighths of depth.
// RL5: Apply exactly the configured number of rules.
// RL6: Rule one takes extended ID 1, label 0x0123.
// RL7: Rule two takes extended ID 2, label 0x0124.
// RL8: Full ID mask compares every identifier bit.
// RL9: IDE and RTR masks compare frame type bits.
// RL10: Cleared loopback select ignores own transmissions.
// RL11: Matches go only to receive FIFO zero.
// RL12: Switched data phase at 2 Mbps, arbitration 1 Mbps.
// RL13: Threshold code 1 means two eighths fill.
// RL14: Receive depth code 2 means eight messages.
// RL15: Payload size code 7 keeps 64 bytes.
// RL16: Transmit depth code 1 means four messages.
// RL17: First matching rule wins; unmatched frames dropped.
// RL18: Stored messages keep header, label and payload.
// RL19: Interrupt stays pending until the host clears it.

module cfrffp_top
    import cfrffp_pkg::*;
#(
    parameter int RX_DEPTH = RX_DEPTH_DEF,
    parameter int TX_DEPTH = TX_DEPTH_DEF
) (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst_b,
    // Configuration
    input  wire logic [COUNT_W-1:0] rule_count,
    input  wire logic [CODE_W-1:0]  rx_fifo_depth_code,
    input  wire logic [CODE_W-1:0]  rx_fifo_irq_threshold,
    input  wire logic [CODE_W-1:0]  rx_fifo_payload_size,
    input  wire logic [CODE_W-1:0]  txrx_fifo_depth_code,
    input  wire logic               rx_fifo_irq_enable,
    // Status
    input  wire logic               rx_irq_clear,
    input  wire logic               rx_overflow_clear,
    output      logic               rx_irq,
    output      logic               rx_overflow,
    output      logic [3:0]         rx_fifo_level,
    // Host transmit load
    input  wire logic               tx_wr_valid,
    output      logic               tx_wr_ready,
    input  wire logic [ID_W-1:0]    tx_wr_id,
    input  wire logic               tx_wr_ide,
    input  wire logic               tx_wr_rtr,
    input  wire logic               tx_wr_fd_format_flag,
    input  wire logic               tx_wr_brs,
    input  wire logic [DLC_W-1:0]   tx_wr_dlc,
    input  wire logic [PAY_W-1:0]   tx_wr_payload,
    // Link transmit frame
    output      logic               link_tx_valid,
    input  wire logic               link_tx_done,
    output      logic [ID_W-1:0]    link_tx_id,
    output      logic               link_tx_ide,
    output      logic               link_tx_rtr,
    output      logic               link_tx_fd_format_flag,
    output      logic               link_tx_brs,
    output      logic [DLC_W-1:0]   link_tx_dlc,
    output      logic [PAY_W-1:0]   link_tx_payload,
    input  wire logic               link_data_phase,
    output      logic               link_fast_rate,
    output      logic               link_bit_tick,
    // Link receive frame
    input  wire logic               link_rx_valid,
    input  wire logic               link_rx_own,
    input  wire logic [ID_W-1:0]    link_rx_id,
    input  wire logic               link_rx_ide,
    input  wire logic               link_rx_rtr,
    input  wire logic               link_rx_fd_format_flag,
    input  wire logic               link_rx_brs,
    input  wire logic [DLC_W-1:0]   link_rx_dlc,
    input  wire logic [PAY_W-1:0]   link_rx_payload,
    // Host receive read
    output      logic               rx_rd_valid,
    input  wire logic               rx_rd_ready,
    output      logic [ID_W-1:0]    rx_rd_id,
    output      logic               rx_rd_ide,
    output      logic               rx_rd_rtr,
    output      logic               rx_rd_fd_format_flag,
    output      logic               rx_rd_brs,
    output      logic [DLC_W-1:0]   rx_rd_dlc,
    output      logic [LABEL_W-1:0] rx_rd_rule_label,
    output      logic [PAY_W-1:0]   rx_rd_payload
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (RX_DEPTH < 4 || RX_DEPTH > 8) begin : g_bad_rx
        $error("RX_DEPTH must lie between 4 and 8");
    end
    if (TX_DEPTH < 2 || TX_DEPTH > 8) begin : g_bad_tx
        $error("TX_DEPTH must lie between 2 and 8");
    end

    localparam int RXF_DEPTH = RX_DEPTH - OUT_BUF_DEPTH;
    localparam int RXF_CW    = $clog2(RXF_DEPTH + 1);
    localparam int TXF_CW    = $clog2(TX_DEPTH + 1);
    localparam int BUF_CW    = $clog2(OUT_BUF_DEPTH + 1);
    localparam int TICK_W    = $clog2(NOM_CYC + 1);

    // ------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------
    // Depth codes decode to message counts; the receive side splits its depth
    // between the main store and the two-entry read buffer.
    wire [3:0]        rx_depth  = 4'(depth_of(rx_fifo_depth_code, RX_DEPTH));  // see RL14
    wire [3:0]        tx_depth  = 4'(depth_of(txrx_fifo_depth_code, TX_DEPTH)); // see RL16
    wire [RXF_CW-1:0] rxf_limit = RXF_CW'(int'(rx_depth) - OUT_BUF_DEPTH);      // see RL3
    wire [TXF_CW-1:0] txf_limit = TXF_CW'(tx_depth);
    wire [6:0]        keep_bytes = 7'(size_bytes(rx_fifo_payload_size));        // see RL15
    // Threshold code n asks for (n+1)/8 of the depth, never less than one message.
    wire [3:0]        thr_raw   = 4'((int'(rx_depth) * (int'(rx_fifo_irq_threshold) + 1))
                                     / THR_DEN);                                // see RL13
    wire [3:0]        irq_level = (thr_raw == 4'h0) ? 4'h1 : thr_raw;

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    // One load is one request; the host waits for ready before the next load,
    // so a frame is never overwritten while it waits for the bus.
    logic [TX_W-1:0] tx_head;
    cfrffp_fifo #(.W(TX_W), .DEPTH(TX_DEPTH)) u_tx_fifo (
        .clock     (clock),
        .rst_b     (rst_b),
        .limit     (txf_limit),
        .in_valid  (tx_wr_valid),                                               // see RL2
        .in_ready  (tx_wr_ready),
        .in_data   ({tx_wr_id, tx_wr_ide, tx_wr_rtr, tx_wr_fd_format_flag, tx_wr_brs,
                     tx_wr_dlc, tx_wr_payload}),
        .out_valid (link_tx_valid),                                             // see RL1
        .out_ready (link_tx_done),
        .out_data  (tx_head),
        .count     ()
    );
    // The head stays presented until the engine reports completion, so the
    // next frame follows at once with no gap added here.
    assign {link_tx_id, link_tx_ide, link_tx_rtr, link_tx_fd_format_flag, link_tx_brs,
            link_tx_dlc, link_tx_payload} = tx_head;                            // see RL1

    // ------------------------------------------------------------
    // Bit-rate tick
    // ------------------------------------------------------------
    // The fast rate applies only inside the data phase of a switched FD frame.
    logic [TICK_W-1:0] tick_cnt_r;
    wire               fast_sel = link_data_phase && link_tx_valid && link_tx_brs
                                  && link_tx_fd_format_flag;                   // see RL12
    wire [TICK_W-1:0]  tick_last = fast_sel ? TICK_W'(DATA_CYC - 1) : TICK_W'(NOM_CYC - 1);
    wire               tick_now  = tick_cnt_r >= tick_last;
    assign link_fast_rate = fast_sel;
    assign link_bit_tick  = tick_now;

    // A count past the fast limit after a rate change ends the bit at once
    // rather than wrapping the counter.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) tick_cnt_r <= '0;
        else        tick_cnt_r <= tick_now ? '0 : tick_cnt_r + 1'b1;           // see RL12
    end

    // ------------------------------------------------------------
    // Acceptance rules
    // ------------------------------------------------------------
    logic [MAX_RULES-1:0] rule_hit;
    for (genvar r = 0; r < MAX_RULES; r++) begin : g_rule
        wire on     = COUNT_W'(r) < rule_count;                                 // see RL5
        wire id_ok  = ((link_rx_id ^ RULE_ID[r]) & RULE_ID_MASK[r]) == '0;      // see RL8
        wire ide_ok = !RULE_IDE_MASK[r] || (link_rx_ide == RULE_IDE[r]);        // see RL9
        wire rtr_ok = !RULE_RTR_MASK[r] || (link_rx_rtr == RULE_RTR[r]);        // see RL9
        wire lb_ok  = RULE_LB[r] ? link_rx_own : !link_rx_own;                  // see RL10
        assign rule_hit[r] = on && id_ok && ide_ok && rtr_ok && lb_ok;
    end

    // Lowest index wins, so the search runs from the top down.
    logic [$clog2(MAX_RULES)-1:0] hit_idx;
    always_comb begin
        hit_idx = '0;
        for (int i = MAX_RULES - 1; i >= 0; i--) begin
            if (rule_hit[i]) hit_idx = ($clog2(MAX_RULES))'(i);                 // see RL17
        end
    end

    wire               hit_any   = |rule_hit;                                   // see RL17
    wire [LABEL_W-1:0] hit_label = RULE_LABEL[hit_idx];                         // see RL6 RL7
    // Dedicated buffers and transmit/receive FIFO targets do not exist in this
    // path; only the receive FIFO route bit leads to storage.
    wire               hit_route = RULE_RX_ROUTE[hit_idx];                      // see RL11
    wire               accept    = link_rx_valid && hit_any && hit_route;

    // Bytes beyond the configured payload size are stored as zero.
    logic [PAY_W-1:0] pay_kept;
    for (genvar b = 0; b < PAY_BYTES; b++) begin : g_keep
        assign pay_kept[b*8 +: 8] = (7'(b) < keep_bytes) ? link_rx_payload[b*8 +: 8] : 8'h00;
    end

    // ------------------------------------------------------------
    // Receive store and read buffer
    // ------------------------------------------------------------
    logic              rxf_ready;
    logic              rxf_valid;
    logic              buf_ready;
    logic [RX_W-1:0]   rxf_head;
    logic [RX_W-1:0]   buf_head;
    logic [RXF_CW-1:0] rxf_count;
    logic [BUF_CW-1:0] buf_count;

    cfrffp_fifo #(.W(RX_W), .DEPTH(RXF_DEPTH)) u_rx_fifo (
        .clock     (clock),
        .rst_b     (rst_b),
        .limit     (rxf_limit),
        .in_valid  (accept),
        .in_ready  (rxf_ready),
        .in_data   ({link_rx_id, link_rx_ide, link_rx_rtr, link_rx_fd_format_flag,
                     link_rx_brs, link_rx_dlc, hit_label, pay_kept}),           // see RL18
        .out_valid (rxf_valid),
        .out_ready (buf_ready),
        .out_data  (rxf_head),
        .count     (rxf_count)
    );

    // The read buffer lets the host stall without holding up the store.
    cfrffp_fifo #(.W(RX_W), .DEPTH(OUT_BUF_DEPTH)) u_rd_buf (
        .clock     (clock),
        .rst_b     (rst_b),
        .limit     (BUF_CW'(OUT_BUF_DEPTH)),
        .in_valid  (rxf_valid),
        .in_ready  (buf_ready),
        .in_data   (rxf_head),
        .out_valid (rx_rd_valid),
        .out_ready (rx_rd_ready),
        .out_data  (buf_head),
        .count     (buf_count)
    );
    assign {rx_rd_id, rx_rd_ide, rx_rd_rtr, rx_rd_fd_format_flag, rx_rd_brs, rx_rd_dlc,
            rx_rd_rule_label, rx_rd_payload} = buf_head;                        // see RL18

    // ------------------------------------------------------------
    // Fill level, interrupt and overflow
    // ------------------------------------------------------------
    logic level_ge_r;
    wire level_ge = rx_fifo_level >= irq_level;
    wire irq_set  = level_ge && !level_ge_r;                                    // see RL4
    wire ovf_set  = accept && !rxf_ready;
    logic rx_irq_r;
    logic rx_overflow_r;
    assign rx_fifo_level = 4'(rxf_count) + 4'(buf_count);
    assign rx_irq        = rx_irq_r && rx_fifo_irq_enable;
    assign rx_overflow   = rx_overflow_r;

    // Sticky flags: a new event in the clearing cycle keeps the flag set.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            level_ge_r    <= 1'b0;
            rx_irq_r      <= 1'b0;
            rx_overflow_r <= 1'b0;
        end else begin
            level_ge_r    <= level_ge;
            rx_irq_r      <= irq_set || (rx_irq_r && !rx_irq_clear);            // see RL19
            rx_overflow_r <= ovf_set || (rx_overflow_r && !rx_overflow_clear);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_fast_hold;
        link_fast_rate[*8] ##1 link_fast_rate;
    endsequence
    sequence s_id_frame(logic [ID_W-1:0] idv);
        link_rx_valid && !link_rx_own && link_rx_ide && !link_rx_rtr && link_rx_id == idv;
    endsequence

    chk_rule_one_label: assert property (@(posedge clock) disable iff (!rst_b) // see RL6
        s_id_frame(29'h0000001) ##0 rule_count >= 8'h01 |-> accept && hit_label == 16'h0123)
        else $error("rule one did not accept with its label");
    chk_rule_two_label: assert property (@(posedge clock) disable iff (!rst_b) // see RL7
        s_id_frame(29'h0000002) ##0 rule_count >= 8'h02 |-> accept && hit_label == 16'h0124)
        else $error("rule two did not accept with its label");
    chk_rule_count_cut: assert property (@(posedge clock) disable iff (!rst_b) // see RL5
        link_rx_valid && rule_count == 8'h01 && link_rx_id == 29'h0000002 |-> !accept)
        else $error("a rule beyond the count was applied");
    chk_own_frame_drop: assert property (@(posedge clock) disable iff (!rst_b) // see RL10
        link_rx_valid && link_rx_own |-> !accept)
        else $error("own transmission was accepted");
    chk_irq_threshold: assert property (@(posedge clock) disable iff (!rst_b)  // see RL4
        rx_fifo_depth_code == 3'h2 && rx_fifo_irq_threshold == 3'h1 && $rose(rx_fifo_level == 4'h2)
        && !level_ge_r |=> rx_irq_r)
        else $error("interrupt missing at two of eight");
    chk_irq_pending: assert property (@(posedge clock) disable iff (!rst_b)    // see RL19
        rx_irq_r && !rx_irq_clear |=> rx_irq_r)
        else $error("interrupt dropped without a clear");
    chk_fast_bit_len: assert property (@(posedge clock) disable iff (!rst_b)   // see RL12
        link_bit_tick && link_fast_rate ##1 s_fast_hold |=> link_bit_tick)
        else $error("data phase bit is not ten cycles");
    chk_nominal_quiet: assert property (@(posedge clock) disable iff (!rst_b)  // see RL12
        link_bit_tick && !link_fast_rate ##1 (!link_fast_rate)[*8] |-> !link_bit_tick)
        else $error("nominal bit ended too early");
    chk_overflow_flag: assert property (@(posedge clock) disable iff (!rst_b)  // see RL3
        accept && !rxf_ready |=> rx_overflow_r)
        else $error("overflow not flagged when store was full");

endmodule : cfrffp_top

// *** tb/cfrffp_link_model.sv ***
`timescale 1ns/10ps
module cfrffp_link_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_b,
    // Frame handshake with the block
    input  wire logic       tx_valid,
    input  wire logic [7:0] delay,
    output      logic       tx_done,
    output      logic       data_phase
);
    logic [7:0] cnt_r;
    // The far engine holds each head frame for delay plus one cycles; zero gives back to back pops.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) cnt_r <= 8'h00;
        else if (tx_valid && cnt_r < delay) cnt_r <= cnt_r + 8'h01;
        else cnt_r <= 8'h00;
    end
    // The second half of each frame time stands for the data phase.
    assign tx_done    = tx_valid && (cnt_r == delay);
    assign data_phase = tx_valid && (cnt_r > (delay >> 1));
endmodule : cfrffp_link_model

// *** tb/test_canfd_rule_filter_fifo_path.sv ***
`timescale 1ns/10ps
module test_canfd_rule_filter_fifo_path import cfrffp_pkg::*; ;
    logic clock = 0, rst_b = 0, tx_wr_valid = 0, link_rx_valid = 0, rx_rd_ready = 0, fd = 1;
    logic rx_irq_clear = 0, rx_overflow_clear = 0, link_rx_own = 0, link_rx_rtr = 0;
    logic link_rx_ide = 1, link_tx_done, link_data_phase, tx_wr_ready, link_tx_valid;
    logic rx_irq, rx_overflow, rx_rd_valid, link_bit_tick;
    logic [COUNT_W-1:0] rule_count = 8'h02;
    logic [7:0] dly = 8'h03;
    logic [3:0] rx_fifo_level, dlc = 4'hF;
    logic [ID_W-1:0] tx_wr_id = '0, link_rx_id = '0, link_tx_id, rx_rd_id;
    logic [LABEL_W-1:0] rx_rd_rule_label;
    logic [PAY_W-1:0] tx_wr_payload = '0, link_rx_payload = '0, link_tx_payload, rx_rd_payload;
    logic [ID_W+LABEL_W+PAY_W-1:0] tx_q[$], rx_q[$];
    int mismatches = 0, checked = 0, cycles = 0, held = 0, t;
    // Clock at 50 ns.
    initial forever #25 clock = ~clock;
    cfrffp_top cfrffp_top_i (.clock, .rst_b, .rule_count, .rx_fifo_depth_code(3'h2),
        .rx_fifo_irq_threshold(3'h1), .rx_fifo_payload_size(3'h7), .txrx_fifo_depth_code(3'h1),
        .rx_fifo_irq_enable(fd), .rx_irq_clear, .rx_overflow_clear, .rx_irq, .rx_overflow,
        .rx_fifo_level, .tx_wr_valid, .tx_wr_ready, .tx_wr_id, .tx_wr_ide(fd), .tx_wr_rtr(1'b0),
        .tx_wr_fd_format_flag(fd), .tx_wr_brs(fd), .tx_wr_dlc(dlc), .tx_wr_payload,
        .link_tx_valid, .link_tx_done, .link_tx_id, .link_tx_ide(), .link_tx_rtr(),
        .link_tx_fd_format_flag(), .link_tx_brs(), .link_tx_dlc(), .link_tx_payload,
        .link_data_phase, .link_fast_rate(), .link_bit_tick, .link_rx_valid, .link_rx_own,
        .link_rx_id, .link_rx_ide, .link_rx_rtr, .link_rx_fd_format_flag(fd), .link_rx_brs(fd),
        .link_rx_dlc(dlc), .link_rx_payload, .rx_rd_valid, .rx_rd_ready, .rx_rd_id,
        .rx_rd_ide(), .rx_rd_rtr(), .rx_rd_fd_format_flag(), .rx_rd_brs(), .rx_rd_dlc(),
        .rx_rd_rule_label, .rx_rd_payload);
    cfrffp_link_model cfrffp_link_model_i (.clock, .rst_b, .tx_valid(link_tx_valid),
        .delay(dly), .tx_done(link_tx_done), .data_phase(link_data_phase));
    task automatic chk(input string what, input logic [63:0] exp, got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cmp_frame(input string what, input logic [ID_W+LABEL_W+PAY_W-1:0] exp, got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_frame
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // Host load; the valid stays up across back to back loads and waits out a refusal.
    task automatic load(input logic [ID_W-1:0] id);
        @(negedge clock);
        tx_wr_id = id;
        tx_wr_payload = {16{$urandom}};
        tx_wr_valid = 1;
        while (!tx_wr_ready) @(negedge clock);
        tx_q.push_back({id, 16'h0000, tx_wr_payload});
        @(posedge clock);
    endtask : load
    // One received frame; the expectation follows the two fixed acceptance entries.
    task automatic rxf(input logic [ID_W-1:0] id, input logic ide, rtr, own);
        @(negedge clock);
        link_rx_id = id;
        link_rx_ide = ide;
        link_rx_rtr = rtr;
        link_rx_own = own;
        link_rx_payload = {16{$urandom}};
        link_rx_valid = 1;
        if (ide && !rtr && !own && held < 8 && (id == 1 && rule_count > 0
                || id == 2 && rule_count > 1)) begin
            rx_q.push_back({id, id == 1 ? 16'h0123 : 16'h0124, link_rx_payload});
            held++;
        end
        @(negedge clock);
        link_rx_valid = 0;
    endtask : rxf
    // Watcher: every pop on either side is matched against the oldest note; also the time limit.
    always @(posedge clock) begin
        cycles++;
        if (rst_b && link_tx_valid && link_tx_done)
            cmp_frame("tx frame", tx_q.pop_front(),
                      {link_tx_id, 16'h0000, link_tx_payload});
        if (rst_b && rx_rd_valid && rx_rd_ready) begin
            cmp_frame("rx message", rx_q.pop_front(),
                      {rx_rd_id, rx_rd_rule_label, rx_rd_payload});
            held--;
        end
        if (cycles > 6000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(17250));
        repeat (6) @(posedge clock);
        @(negedge clock) rst_b = 1;
        @(posedge link_bit_tick) t = cycles;
        @(posedge link_bit_tick) chk("bit time", NOM_CYC, cycles - t);
        // Slow engine: four loads fill the store, then a fast drain sends them back to back.
        dly = 8'h3C;
        for (int i = 0; i < 4; i++) load($urandom);
        @(negedge clock) chk("tx ready", 0, tx_wr_ready);
        tx_wr_valid = 0;
        repeat (50) @(negedge clock);
        dly = 8'h00;
        load(1);
        load(2);
        @(negedge clock) tx_wr_valid = 0;
        wait (tx_q.size() == 0);
        $display("transmit test done");
        @(negedge clock) rx_rd_ready = 1;
        rxf(1, 1, 0, 0); rxf(2, 1, 0, 0); rxf(3, 1, 0, 0); rxf(29'h10000001, 1, 0, 0);
        rxf(1, 1, 1, 0); rxf(2, 0, 0, 0); rxf(1, 1, 0, 1);
        rule_count = 8'h01; rxf(2, 1, 0, 0); rxf(1, 1, 0, 0);
        rule_count = 8'h00; rxf(1, 1, 0, 0);
        rule_count = 8'h02;
        wait (held == 0);
        $display("filter test done");
        @(negedge clock) rx_rd_ready = 0;
        rxf(1, 1, 0, 0); rxf(2, 1, 0, 0);
        repeat (2) @(negedge clock);
        chk("irq at two", 1, rx_irq);
        rx_irq_clear = 1;
        @(negedge clock) rx_irq_clear = 0;
        for (int i = 0; i < 7; i++) rxf(1, 1, 0, 0);
        @(negedge clock) chk("irq held clear", 0, rx_irq);
        chk("level", 8, rx_fifo_level);
        chk("overflow", 1, rx_overflow);
        rx_rd_ready = 1;
        wait (held == 0);
        @(negedge clock) rx_rd_ready = 0;
        rxf(2, 1, 0, 0); rxf(1, 1, 0, 0);
        repeat (2) @(negedge clock);
        chk("irq again", 1, rx_irq);
        rx_rd_ready = 1;
        wait (held == 0);
        $display("fill test done");
        end_of_test();
    end
endmodule : test_canfd_rule_filter_fifo_path
